/* ddr2_cke_command_state_rules_tb.sv */
// bench: controller end drives device end across the pin interface
// assumes dram_cmd_pkg constants and a 125 MHz clock
`timescale 1ns/10ps
module ddr2_cke_command_state_rules_tb
    import dram_cmd_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_cmd = 3'h0;
    logic [2:0] req_ba = 3'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [15:0] req_data = 16'h0000;
    logic req_mask = 1'b0;
    logic req_cke = 1'b0;
    logic odt_enabled = 1'b0;
    logic ocd_cal = 1'b0;
    logic req_ready, active_pd, illegal, odt_active, wr_strobe, refresh_pulse;
    logic [2:0] state;
    logic [7:0] open_banks;
    logic [15:0] wr_data;
    int errors = 0;
    int tests_run = 0;
    time t_take;
    time t0;
    dram_cmd_if link();
    always #4 clk = ~clk;
    dram_ctrl_end #(.pd_limit(50)) u_dram_ctrl_end (.clk(clk), .nrst(nrst), .link(link.ctrl),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
        .req_data(req_data), .req_mask(req_mask), .req_cke(req_cke), .odt_enabled(odt_enabled),
        .ocd_cal(ocd_cal), .req_ready(req_ready));
    dram_dev_end u_dram_dev_end (.clk(clk), .nrst(nrst), .link(link.dev), .state(state),
        .active_pd(active_pd), .open_banks(open_banks), .illegal(illegal), .odt_active(odt_active),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .refresh_pulse(refresh_pulse));
    dram_cmd_checker #(.pd_limit(50)) u_dram_cmd_checker (.clk(clk), .nrst(nrst), .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
        .dq_valid(link.dq_valid));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // outputs sampled one edge after the take, where the device answers
    task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [12:0] a,
                         input logic [15:0] d, input logic m, input logic k);
        int n;
        n = 0;
        @(negedge clk);
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        req_data = d;
        req_mask = m;
        req_cke = k;
        // ready is judged only once it has settled on the new request
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("req_ready", 16'h0001, {15'h0000, req_ready});
        req_valid = 1'b1;
        @(posedge clk);
        t_take = $time;
        @(negedge clk);
        req_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_idle;
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("state", st_idle, state);
        issue(3'h6, ba_emr1, 13'h0044, 16'h0000, 1'b0, 1'b1);
        check("illegal", 16'h0000, illegal);
        issue(3'h5, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("refresh_pulse", 16'h0001, refresh_pulse);
        issue(3'h1, 3'h2, 13'h0010, 16'h0000, 1'b0, 1'b1);
        check("open_banks", 16'h0004, open_banks);
        $display("test idle done");
    endtask
    task automatic t_burst;
        issue(3'h1, 3'h5, 13'h0020, 16'h0000, 1'b0, 1'b1);
        check("open_banks", 16'h0024, open_banks);
        issue(3'h3, 3'h2, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("state", st_read, state);
        issue(3'h4, 3'h5, 13'h0008, 16'ha5a5, 1'b0, 1'b1);
        check("wr_data", 16'ha5a5, wr_data);
        check("wr_strobe", 16'h0001, wr_strobe);
        check("state", st_write, state);
        issue(3'h4, 3'h5, 13'h0010, 16'h5a5a, 1'b1, 1'b1);
        check("wr_strobe", 16'h0000, wr_strobe);
        check("wr_data", 16'ha5a5, wr_data);
        check("illegal", 16'h0000, illegal);
        check("state", st_write, state);
        $display("test burst done");
    endtask
    task automatic t_power_down;
        @(negedge clk);
        odt_enabled = 1'b1;
        ocd_cal = 1'b1;
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
        check("cke", 16'h0001, link.cke);
        @(negedge clk);
        ocd_cal = 1'b0;
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
        check("state", st_power_down, state);
        check("active_pd", 16'h0001, active_pd);
        check("odt", 16'h0001, link.odt);
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("state", st_active, state);
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
        check("state", st_power_down, state);
        repeat (60) @(posedge clk);
        #1;
        check("state", st_active, state);
        $display("test power down done");
    endtask
    task automatic t_precharge;
        issue(3'h2, 3'h5, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("open_banks", 16'h0004, open_banks);
        issue(3'h2, 3'h0, 13'h0400, 16'h0000, 1'b0, 1'b1);
        check("state", st_idle, state);
        $display("test precharge done");
    endtask
    task automatic t_self_refresh;
        issue(3'h5, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
        check("state", st_self_refresh, state);
        check("odt_active", 16'h0000, odt_active);
        issue(3'h0, 3'h0, 13'h0000, 16'h0000, 1'b0, 1'b1);
        t0 = t_take;
        check("state", st_idle, state);
        issue(3'h1, 3'h1, 13'h0030, 16'h0000, 1'b0, 1'b1);
        check("xsnr wait", 16'h0001, t_take - t0 >= xsnr_clocks * 8);
        issue(3'h3, 3'h1, 13'h0000, 16'h0000, 1'b0, 1'b1);
        check("xsrd wait", 16'h0001, t_take - t0 >= xsrd_clocks * 8);
        check("state", st_read, state);
        $display("test self refresh done");
    endtask
    task automatic finish_test;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial begin
        #(8 * 4000);
        errors++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_idle;
        t_burst;
        t_power_down;
        t_precharge;
        t_self_refresh;
        finish_test;
    end
endmodule

/* dram_cmd_checker.sv */
// pin-level checks between controller end and device end
// assumes one clock, nrst async low, signals taken from dram_cmd_if
`timescale 1ns/10ps
module dram_cmd_checker
    import dram_cmd_pkg::*;
#(
    parameter int xsrd = xsrd_clocks,
    parameter int burst_len = burst_beats,
    parameter int pd_limit = 1000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic dq_valid
);
    logic quiet, act, pre, rd, wr, rf, mrs;
    logic cke_q;
    logic self_ref;
    logic [7:0] open_map;
    int xs_cnt;
    int b_cnt;
    int low_cnt;
    assign quiet = cs_n | (ras_n & cas_n & we_n);
    assign act = !cs_n & !ras_n & cas_n & we_n;
    assign pre = !cs_n & !ras_n & cas_n & !we_n;
    assign rd = !cs_n & ras_n & !cas_n & we_n;
    assign wr = !cs_n & ras_n & !cas_n & !we_n;
    assign rf = !cs_n & !ras_n & !cas_n & we_n;
    assign mrs = !cs_n & !ras_n & !cas_n & !we_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // bank map rebuilt from pins, so device outputs are not trusted here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            open_map <= 8'h00;
        end else if (act) begin
            open_map[ba] <= 1'b1;
        end else if (pre) begin
            open_map <= addr[10] ? 8'h00 : (open_map & ~(8'h01 << ba));
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cke_q <= 1'b0;
            self_ref <= 1'b0;
        end else begin
            cke_q <= cke;
            if (cke_q && !cke && rf) begin
                self_ref <= 1'b1;
            end else if (cke) begin
                self_ref <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xs_cnt <= 0;
        end else if (self_ref && cke) begin
            xs_cnt <= xsrd - 1;
        end else if (xs_cnt > 0) begin
            xs_cnt <= xs_cnt - 1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            b_cnt <= 0;
        end else if (rd || wr) begin
            b_cnt <= burst_len - 1;
        end else if (b_cnt > 0) begin
            b_cnt <= b_cnt - 1;
        end
    end
    // power-down length in sampled low edges; self-refresh refreshes itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 0;
        end else if (cke || self_ref) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end
    a_cke_hold_three: assert property ($changed(cke) |=> $stable(cke) [*2])
        else $error("clock enable changed within three edges");
    a_cke_fall_cmd: assert property ($fell(cke) |-> quiet || rf)
        else $error("clock enable fell with a busy command");
    a_cke_rise_quiet: assert property ($rose(cke) |-> quiet)
        else $error("clock enable rose with a busy command");
    a_sr_from_idle: assert property ($fell(cke) && rf |-> open_map == 8'h00)
        else $error("self refresh entered with a bank open");
    a_xsnr_quiet: assert property (xs_cnt > xsrd - xsnr_clocks |-> quiet)
        else $error("command inside the non-read exit interval");
    a_xsrd_read: assert property (rd |-> xs_cnt == 0)
        else $error("read too soon after self refresh exit");
    a_no_pd_burst: assert property ($fell(cke) |-> b_cnt == 0)
        else $error("clock enable fell during a burst");
    a_burst_legal: assert property (b_cnt != 0 |-> !(rf || mrs))
        else $error("refresh or mode set during a burst");
    a_idle_no_rw: assert property (rd || wr |-> open_map != 8'h00)
        else $error("read or write with no bank open");
    a_act_closed: assert property (act |-> !open_map[ba])
        else $error("activate on an open bank");
    a_write_data: assert property (wr |-> dq_valid)
        else $error("write without its data beat");
    a_pd_limited: assert property (!cke |-> low_cnt <= pd_limit)
        else $error("power down held too long");
    cover property (wr && b_cnt != 0);
    cover property ($fell(cke) && rf);
    cover property ($rose(cke) && self_ref);
    cover property ($fell(cke) && open_map != 8'h00);
endmodule

/* dram_cmd_if.sv */
// command and clock-enable pins between controller and device
// assumes one shared clock; pins are plain wires, no tri-state here
`timescale 1ns/10ps
interface dram_cmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [12:0] addr;
    logic odt;
    logic dm;
    logic [15:0] dq;
    logic dq_valid;

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq, dq_valid);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq, dq_valid);
endinterface

/* dram_cmd_pkg.sv */
// shared constants and types for the clock-enable and command-legality pair
// assumes both ends run on one 125 MHz clock
package dram_cmd_pkg;
    localparam int clk_period_ns = 8;
    localparam int cke_hold_clocks = 3;
    localparam int xsrd_clocks = 200;
    localparam int xsnr_ns = 198;
    localparam int xsnr_clocks = (xsnr_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int burst_beats = 4;
    localparam int bank_count = 8;
    localparam logic [2:0] ba_emr1 = 3'h1;
    localparam int odt_bit_a = 2;
    localparam int odt_bit_b = 6;

    typedef enum logic [3:0] {
        cmd_deselect, cmd_nop, cmd_act, cmd_pre, cmd_read, cmd_write,
        cmd_ref, cmd_mrs
    } cmd_t;

    typedef enum logic [2:0] {
        st_idle, st_active, st_read, st_write, st_power_down, st_self_refresh
    } dev_state_t;

    // decode from chip select, row, column, write strobes (active low pins)
    function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        cmd_t c;
        c = cmd_deselect;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h7: c = cmd_nop;
                3'h3: c = cmd_act;
                3'h2: c = cmd_pre;
                3'h5: c = cmd_read;
                3'h4: c = cmd_write;
                3'h1: c = cmd_ref;
                3'h0: c = cmd_mrs;
                default: c = cmd_nop;
            endcase
        end
        return c;
    endfunction

    function automatic logic is_quiet(input cmd_t c);
        return (c == cmd_deselect) || (c == cmd_nop);
    endfunction
endpackage

/* dram_ctrl_end.sv */
// controller end: issues requests while keeping clock-enable and command rules
// assumes a user issues one request at a time and waits for req_ready
`timescale 1ns/10ps
module dram_ctrl_end
    import dram_cmd_pkg::*;
#(
    parameter int hold_clocks = cke_hold_clocks,
    parameter int xsrd = xsrd_clocks,
    parameter int burst_len = burst_beats,
    parameter int pd_limit = 1000
) (
    input wire logic clk,
    input wire logic nrst,
    dram_cmd_if.ctrl link,
    input wire logic req_valid,
    input wire logic [2:0] req_cmd,
    input wire logic [2:0] req_ba,
    input wire logic [12:0] req_addr,
    input wire logic [15:0] req_data,
    input wire logic req_mask,
    input wire logic req_cke,
    input wire logic odt_enabled,
    input wire logic ocd_cal,
    output logic req_ready
);
    if (hold_clocks < 1 || xsrd < xsnr_clocks || burst_len < 1 || pd_limit < 1 || pd_limit > 65535) begin
        $error("bad parameters");
    end

    // req_cmd: 0 deselect 1 act 2 pre 3 read 4 write 5 ref 6 mrs
    logic [15:0] since_cke, busy, since_sr;
    logic [2:0] last_cmd;
    logic sr_exit_pending, in_sr;
    logic want_low, cke_change_ok, is_read, quiet_ok, cmd_ok, force_wake, cmd_issue;

    assign want_low = !req_cke && !ocd_cal;
    assign cke_change_ok = (since_cke >= 16'(hold_clocks - 1)) && busy == 16'h0;
    assign is_read = req_cmd == 3'h3;
    assign quiet_ok = !sr_exit_pending || (since_sr >= 16'(xsnr_clocks) && (!is_read || since_sr >= 16'(xsrd)));
    // only a deselect or a same-direction burst interrupt may overlap a busy window
    assign cmd_ok = busy == 16'h0 || req_cmd == 3'h0
                    || (req_cmd == last_cmd && (is_read || req_cmd == 3'h4));
    // no refresh runs in power-down, so a long stay is ended here
    assign force_wake = !link.cke && !in_sr && since_cke >= 16'(pd_limit);
    assign req_ready = link.cke ? (want_low ? cke_change_ok : quiet_ok && cmd_ok)
                                : !want_low && cke_change_ok;
    // cke edges carry only a quiet command, or refresh for self-refresh entry
    assign cmd_issue = req_valid && req_ready && (link.cke == !want_low || (link.cke && req_cmd == 3'h5));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link.cke <= 1'b0;
            since_cke <= 16'h0;
            in_sr <= 1'b0;
        end else begin
            if (req_valid && req_ready && (link.cke == want_low)) begin
                link.cke <= !link.cke;
                since_cke <= 16'h0;
                in_sr <= want_low && req_cmd == 3'h5;
            end else if (force_wake) begin
                link.cke <= 1'b1;
                since_cke <= 16'h0;
            end else if (since_cke != 16'hffff) begin
                since_cke <= since_cke + 16'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            link.ba <= 3'h0;
            link.addr <= 13'h0;
            busy <= 16'h0;
            last_cmd <= 3'h0;
        end else begin
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            if (busy != 16'h0) busy <= busy - 16'h1;
            if (cmd_issue) begin
                last_cmd <= req_cmd;
                link.ba <= req_ba;
                link.addr <= req_addr;
                link.cs_n <= req_cmd == 3'h0;
                case (req_cmd)
                    3'h1: {link.ras_n, link.cas_n, link.we_n} <= 3'h3;
                    3'h2: {link.ras_n, link.cas_n, link.we_n} <= 3'h2;
                    3'h3: {link.ras_n, link.cas_n, link.we_n} <= 3'h5;
                    3'h4: {link.ras_n, link.cas_n, link.we_n} <= 3'h4;
                    3'h5: {link.ras_n, link.cas_n, link.we_n} <= 3'h1;
                    3'h6: {link.ras_n, link.cas_n, link.we_n} <= 3'h0;
                    default: {link.ras_n, link.cas_n, link.we_n} <= 3'h7;
                endcase
                if (req_cmd >= 3'h2 && req_cmd <= 3'h4 || req_cmd == 3'h6) busy <= 16'(burst_len);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sr_exit_pending <= 1'b0;
            since_sr <= 16'h0;
        end else if (in_sr && !link.cke && req_valid && req_ready && !want_low) begin
            sr_exit_pending <= 1'b1;
            since_sr <= 16'h0;
        end else if (sr_exit_pending) begin
            since_sr <= since_sr + 16'h1;
            if (since_sr >= 16'(xsrd)) sr_exit_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link.odt <= 1'b0;
            link.dm <= 1'b1;
            link.dq <= 16'h0;
            link.dq_valid <= 1'b0;
        end else begin
            link.odt <= odt_enabled && !in_sr;
            link.dq_valid <= req_valid && req_ready && req_cmd == 3'h4;
            link.dm <= req_mask;
            link.dq <= req_data;
        end
    end
endmodule

/* dram_dev_end.sv */
// device end: clock-enable state tracking and command legality
// assumes pins are on the same clock as clk
`timescale 1ns/10ps
module dram_dev_end
    import dram_cmd_pkg::*;
#(
    parameter int burst_len = burst_beats,
    parameter int banks = bank_count
) (
    input wire logic clk,
    input wire logic nrst,
    dram_cmd_if.dev link,
    output logic [2:0] state,
    output logic active_pd,
    output logic [banks-1:0] open_banks,
    output logic illegal,
    output logic odt_active,
    output logic wr_strobe,
    output logic [15:0] wr_data,
    output logic refresh_pulse
);
    if (burst_len < 1 || burst_len > 8 || banks != 8) begin
        $error("unsupported parameters");
    end

    dev_state_t cur, next_cur;
    logic cke_prev;
    logic [banks-1:0] next_open;
    logic [3:0] beats;
    logic pd_with_open;
    logic bad;
    cmd_t cmd;

    assign cmd = decode_cmd(link.cs_n, link.ras_n, link.cas_n, link.we_n);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cke_prev <= 1'b0;
        end else begin
            cke_prev <= link.cke;
        end
    end

    // odt is deliberately not an input of the transition logic
    always_comb begin
        next_cur = cur;
        next_open = open_banks;
        bad = 1'b0;
        case (cur)
            st_power_down, st_self_refresh: begin
                if (!cke_prev && link.cke) begin
                    if (!is_quiet(cmd)) bad = 1'b1;
                    next_cur = (cur == st_power_down && pd_with_open) ? st_active : st_idle;
                end
            end
            st_idle: begin
                if (cke_prev && !link.cke) begin
                    if (cmd == cmd_ref) next_cur = st_self_refresh;
                    else if (is_quiet(cmd)) next_cur = st_power_down;
                    else bad = 1'b1;
                end else begin
                    case (cmd)
                        cmd_act: begin
                            next_open[link.ba] = 1'b1;
                            next_cur = st_active;
                        end
                        cmd_read, cmd_write: bad = 1'b1;
                        default: next_cur = st_idle;
                    endcase
                end
            end
            st_active: begin
                if (cke_prev && !link.cke) begin
                    if (is_quiet(cmd)) next_cur = st_power_down;
                    else bad = 1'b1;
                end else begin
                    case (cmd)
                        cmd_read: next_cur = st_read;
                        cmd_write: next_cur = st_write;
                        cmd_pre: begin
                            if (link.addr[10]) next_open = '0;
                            else next_open[link.ba] = 1'b0;
                            if (link.addr[10] || (open_banks & ~(banks'(1) << link.ba)) == '0)
                                next_cur = st_idle;
                        end
                        cmd_act: begin
                            if (open_banks[link.ba]) bad = 1'b1;
                            else next_open[link.ba] = 1'b1;
                        end
                        cmd_ref, cmd_mrs: bad = 1'b1;
                        default: next_cur = st_active;
                    endcase
                end
            end
            st_read, st_write: begin
                if (!link.cke) begin
                    bad = 1'b1;
                end else begin
                    case (cmd)
                        cmd_deselect, cmd_nop: begin
                            if (beats == 4'(burst_len - 1)) next_cur = st_active;
                        end
                        cmd_read: if (cur != st_read) bad = 1'b1;
                        cmd_write: if (cur != st_write) bad = 1'b1;
                        cmd_act: if (open_banks[link.ba]) bad = 1'b1;
                        default: bad = 1'b1;
                    endcase
                end
            end
            default: next_cur = st_idle;
        endcase
        if (bad) begin
            next_cur = cur;
            next_open = open_banks;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= st_idle;
            open_banks <= '0;
            pd_with_open <= 1'b0;
        end else begin
            cur <= next_cur;
            open_banks <= next_open;
            if (next_cur == st_power_down && cur != st_power_down)
                pd_with_open <= (open_banks != '0);
        end
    end

    // burst beat counter restarts on an interrupting command
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            beats <= 4'h0;
        end else if ((next_cur == st_read || next_cur == st_write) && (cmd == cmd_read || cmd == cmd_write)) begin
            beats <= 4'h0;
        end else if (cur == st_read || cur == st_write) begin
            beats <= beats + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_strobe <= 1'b0;
            wr_data <= 16'h0;
        end else begin
            wr_strobe <= link.dq_valid && !link.dm;
            if (link.dq_valid && !link.dm) wr_data <= link.dq;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            illegal <= 1'b0;
            refresh_pulse <= 1'b0;
            odt_active <= 1'b0;
        end else begin
            illegal <= bad;
            refresh_pulse <= (cur == st_idle) && link.cke && cke_prev && cmd == cmd_ref;
            odt_active <= link.odt && next_cur != st_self_refresh;
        end
    end

    assign state = 3'(cur);
    assign active_pd = (cur == st_power_down) && pd_with_open;
endmodule
